// [core/lei_regs_cfg.svh]
// Operation
// - eight-bit link error down-counter on errors
// - at zero reload threshold, flag threshold hit
// - threshold write also loads link error counter
// - reset clears link error counter to zero
// - count register read returns captured snapshot
// - writes to read-only registers rejected, flagged
// - sense flag sets after 160 ns high
// - sense flag sticky until bus write clears
// - enable pins follow user register bits two, three
// - upper user bits reset zero, no effect
// - read-only revision identifier register
// - injection down-counter decrements every 80 ns
// - injection counter runs only in modes 01, 10
// - injection reload at zero or threshold write
// - reset clears injection counter to zero
// - injection count read returns captured snapshot
`ifndef LEI_REGS_CFG_SVH
`define LEI_REGS_CFG_SVH
// ****************************************************************
// register addresses
// ****************************************************************
`define LEI_ADDR_THRESHOLD 5'h15
`define LEI_ADDR_LE_COUNT  5'h16
`define LEI_ADDR_USER      5'h17
`define LEI_ADDR_REV       5'h18
`define LEI_ADDR_INJ_COUNT 5'h19
// ****************************************************************
// fields and reset values
// ****************************************************************
`define LEI_BIT_SENSE0     0
`define LEI_BIT_SENSE1     1
`define LEI_BIT_ENABLE0    2
`define LEI_BIT_ENABLE1    3
`define LEI_BIT_RES_LO     4
`define LEI_BIT_RES_HI     7
`define LEI_BYTE_ZERO      8'h00
`define LEI_INJ_ONE_SHOT   2'h1
`define LEI_INJ_PERIODIC   2'h2
// ****************************************************************
// timing
// ****************************************************************
`define LEI_CLK_PERIOD_NS  50
`define LEI_BYTE_PERIOD_NS 80
`define LEI_SENSE_MIN_NS   160
`endif

// [core/lei_regs_pkg.sv]
package lei_regs_pkg;
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [4:0] addr;
    logic [7:0] wdata;
  } lei_bus_req_type;
endpackage : lei_regs_pkg

// [core/lei_regs.sv]
`timescale 1ns/1ps
`include "lei_regs_cfg.svh"
module lei_regs #(
  parameter logic [7:0] REVISION = 8'h01,  // value is arbitrary
  parameter int         SENSE_SAMPLES = 2
) (
  // clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       reset,
  // control bus
  input  wire lei_regs_pkg::lei_bus_req_type bus_req,
  output logic [7:0]                      bus_rdata,
  // receive and transmit side
  input  wire logic                       byte_tick,
  input  wire logic                       link_error,
  input  wire logic [1:0]                 injection_control,
  input  wire logic [7:0]                 injection_threshold,
  input  wire logic                       injection_threshold_wr,
  // interrupt condition events
  output logic                            link_error_threshold_hit,
  output logic                            write_reject_flag,
  // user pins
  input  wire logic                       sense_pin_0,
  input  wire logic                       sense_pin_1,
  output logic                            enable_pin_0,
  output logic                            enable_pin_1
);
  // ****************************************************************
  // bus decode
  // ****************************************************************
  function automatic logic hit(input logic [4:0] a, input logic [4:0] b);
    return a == b;
  endfunction : hit

  logic       wr_thr, wr_user, wr_ro;
  logic [7:0] thr_q, le_cnt_q, inj_cnt_q, rdata_d;
  logic [1:0] sense_q, enable_q;
  logic [1:0] sense_run_q [2];
  logic       inj_active;

  assign wr_thr  = bus_req.wr && hit(bus_req.addr, `LEI_ADDR_THRESHOLD);
  assign wr_user = bus_req.wr && hit(bus_req.addr, `LEI_ADDR_USER);
  assign wr_ro   = bus_req.wr && (hit(bus_req.addr, `LEI_ADDR_LE_COUNT) ||
                   hit(bus_req.addr, `LEI_ADDR_REV) ||
                   hit(bus_req.addr, `LEI_ADDR_INJ_COUNT));

  // ****************************************************************
  // link error counter
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      thr_q <= `LEI_BYTE_ZERO;
    end else if (wr_thr) begin
      thr_q <= bus_req.wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    link_error_threshold_hit <= 1'b0;
    if (reset) begin
      le_cnt_q <= `LEI_BYTE_ZERO;
    end else if (wr_thr) begin
      le_cnt_q <= bus_req.wdata;
    end else if (le_cnt_q == `LEI_BYTE_ZERO) begin
      le_cnt_q                 <= thr_q;
      link_error_threshold_hit <= 1'b1;
    end else if (link_error) begin
      le_cnt_q <= le_cnt_q - 8'h01;
    end
  end

  // ****************************************************************
  // injection counter
  // ****************************************************************
  assign inj_active = (injection_control == `LEI_INJ_ONE_SHOT) ||
                      (injection_control == `LEI_INJ_PERIODIC);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      inj_cnt_q <= `LEI_BYTE_ZERO;
    end else if (injection_threshold_wr) begin
      inj_cnt_q <= injection_threshold;
    end else if (inj_active && byte_tick) begin
      if (inj_cnt_q == `LEI_BYTE_ZERO) begin
        inj_cnt_q <= injection_threshold;
      end else begin
        inj_cnt_q <= inj_cnt_q - 8'h01;
      end
    end
  end

  // ****************************************************************
  // user register and sense filter
  // ****************************************************************
  logic [1:0] pins;
  assign pins = {sense_pin_1, sense_pin_0};

  generate
    for (genvar i = 0; i < 2; i++) begin : g_sense
      always_ff @(posedge ref_clk) begin
        if (reset) begin
          sense_run_q[i] <= 2'h0;
        end else if (!pins[i]) begin
          sense_run_q[i] <= 2'h0;
        end else if (byte_tick && sense_run_q[i] < 2'(SENSE_SAMPLES)) begin
          sense_run_q[i] <= sense_run_q[i] + 2'h1;
        end
      end

      always_ff @(posedge ref_clk) begin
        if (reset) begin
          sense_q[i] <= 1'b0;
        end else if (sense_run_q[i] == 2'(SENSE_SAMPLES)) begin
          sense_q[i] <= 1'b1;  // set wins over clear
        end else if (wr_user) begin
          sense_q[i] <= bus_req.wdata[i] & sense_q[i];
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      enable_q <= 2'h0;
    end else if (wr_user) begin
      enable_q <= bus_req.wdata[`LEI_BIT_ENABLE1:`LEI_BIT_ENABLE0];
    end
  end

  assign enable_pin_0 = enable_q[0];
  assign enable_pin_1 = enable_q[1];

  // ****************************************************************
  // reject flag and read data
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      write_reject_flag <= 1'b0;
    end else begin
      write_reject_flag <= wr_ro;
    end
  end

  always_comb begin
    rdata_d = `LEI_BYTE_ZERO;
    if (hit(bus_req.addr, `LEI_ADDR_THRESHOLD)) begin
      rdata_d = thr_q;
    end else if (hit(bus_req.addr, `LEI_ADDR_LE_COUNT)) begin
      rdata_d = le_cnt_q;
    end else if (hit(bus_req.addr, `LEI_ADDR_USER)) begin
      rdata_d = {4'h0, enable_q, sense_q};
    end else if (hit(bus_req.addr, `LEI_ADDR_REV)) begin
      rdata_d = REVISION;
    end else if (hit(bus_req.addr, `LEI_ADDR_INJ_COUNT)) begin
      rdata_d = inj_cnt_q;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      bus_rdata <= `LEI_BYTE_ZERO;
    end else if (bus_req.rd) begin
      bus_rdata <= rdata_d;
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  sequence s_zero_count;
    !wr_thr && le_cnt_q == `LEI_BYTE_ZERO;
  endsequence

  a_le_reload_hit: assert property (@(posedge ref_clk) disable iff (reset)
    s_zero_count |=> link_error_threshold_hit && le_cnt_q == $past(thr_q))
    else $error("link error reload missing");
  a_le_decrement: assert property (@(posedge ref_clk) disable iff (reset)
    !wr_thr && le_cnt_q != 8'h00 && link_error |=> le_cnt_q == $past(le_cnt_q) - 8'h01)
    else $error("link error count not decremented");
  a_thr_load: assert property (@(posedge ref_clk) disable iff (reset)
    wr_thr |=> le_cnt_q == $past(bus_req.wdata) && thr_q == $past(bus_req.wdata))
    else $error("threshold write did not load counter");
  a_reset_clear: assert property (@(posedge ref_clk)
    reset |=> le_cnt_q == 8'h00 && inj_cnt_q == 8'h00)
    else $error("counters not cleared by reset");
  a_reject_flag: assert property (@(posedge ref_clk) disable iff (reset)
    wr_ro |=> write_reject_flag)
    else $error("read-only write not rejected");
  a_inj_hold: assert property (@(posedge ref_clk) disable iff (reset)
    !inj_active && !injection_threshold_wr |=> $stable(inj_cnt_q))
    else $error("injection counter ran while idle");
  a_inj_step: assert property (@(posedge ref_clk) disable iff (reset)
    inj_active && byte_tick && !injection_threshold_wr && inj_cnt_q != 8'h00
    |=> inj_cnt_q == $past(inj_cnt_q) - 8'h01)
    else $error("injection counter not decremented");
  a_sense_sticky: assert property (@(posedge ref_clk) disable iff (reset)
    sense_q[0] && !wr_user |=> sense_q[0])
    else $error("sense flag lost without a write");
  a_enable_pins: assert property (@(posedge ref_clk) disable iff (reset)
    wr_user |=> enable_pin_0 == $past(bus_req.wdata[`LEI_BIT_ENABLE0]) &&
                enable_pin_1 == $past(bus_req.wdata[`LEI_BIT_ENABLE1]))
    else $error("enable pins do not follow write");
  a_read_snap: assert property (@(posedge ref_clk) disable iff (reset)
    bus_req.rd && hit(bus_req.addr, `LEI_ADDR_INJ_COUNT) |=> bus_rdata == $past(inj_cnt_q))
    else $error("injection snapshot wrong");

  // ****************************************************************
  // link error counter and reject flag checks
  // ****************************************************************
  sequence s_le_idle;
    !wr_thr && le_cnt_q != `LEI_BYTE_ZERO && !link_error;
  endsequence

  sequence s_le_busy;
    wr_thr || le_cnt_q != `LEI_BYTE_ZERO;
  endsequence

  a_le_hold: assert property (@(posedge ref_clk) disable iff (reset)
    s_le_idle |=> $stable(le_cnt_q))
    else $error("link error count moved without an error");
  a_hit_only_zero: assert property (@(posedge ref_clk) disable iff (reset)
    s_le_busy |=> !link_error_threshold_hit)
    else $error("threshold hit without a zero count");
  a_reject_ignored: assert property (@(posedge ref_clk) disable iff (reset)
    wr_ro |=> $stable(thr_q) && $stable(enable_q))
    else $error("rejected write changed a register");
  a_reject_only: assert property (@(posedge ref_clk) disable iff (reset)
    !wr_ro |=> !write_reject_flag)
    else $error("reject flag without a rejected write");

  // ****************************************************************
  // injection counter checks
  // ****************************************************************
  sequence s_inj_tick;
    inj_active && byte_tick && !injection_threshold_wr;
  endsequence

  sequence s_inj_tick_at_zero;
    s_inj_tick ##0 inj_cnt_q == `LEI_BYTE_ZERO;
  endsequence

  a_inj_load: assert property (@(posedge ref_clk) disable iff (reset)
    injection_threshold_wr |=> inj_cnt_q == $past(injection_threshold))
    else $error("injection threshold write did not load counter");
  a_inj_reload: assert property (@(posedge ref_clk) disable iff (reset)
    s_inj_tick_at_zero |=> inj_cnt_q == $past(injection_threshold))
    else $error("injection counter not reloaded at zero");
  a_inj_no_tick: assert property (@(posedge ref_clk) disable iff (reset)
    inj_active && !byte_tick && !injection_threshold_wr |=> $stable(inj_cnt_q))
    else $error("injection counter moved between byte ticks");

  // ****************************************************************
  // user register checks
  // ****************************************************************
  generate
    for (genvar k = 0; k < 2; k++) begin : g_sense_chk
      sequence s_run_full;
        sense_run_q[k] == 2'(SENSE_SAMPLES);
      endsequence

      sequence s_run_short;
        sense_run_q[k] != 2'(SENSE_SAMPLES);
      endsequence

      a_sense_set: assert property (@(posedge ref_clk) disable iff (reset)
        s_run_full |=> sense_q[k])
        else $error("sense flag not set after a long high");
      a_sense_quiet: assert property (@(posedge ref_clk) disable iff (reset)
        !sense_q[k] ##0 s_run_short |=> !sense_q[k])
        else $error("sense flag set by a short high");
      a_sense_clear: assert property (@(posedge ref_clk) disable iff (reset)
        wr_user && !bus_req.wdata[k] ##0 s_run_short |=> !sense_q[k])
        else $error("sense flag not cleared by a zero write");
    end
  endgenerate

  a_enable_hold: assert property (@(posedge ref_clk) disable iff (reset)
    !wr_user |=> $stable(enable_pin_0) && $stable(enable_pin_1))
    else $error("enable pins moved without a write");
  a_reset_outputs: assert property (@(posedge ref_clk)
    reset |=> !link_error_threshold_hit && !write_reject_flag &&
              enable_q == 2'h0 && sense_q == 2'h0 && bus_rdata == `LEI_BYTE_ZERO)
    else $error("outputs not cleared by reset");

  // ****************************************************************
  // read data checks
  // ****************************************************************
  sequence s_read_of(logic [4:0] a);
    bus_req.rd && hit(bus_req.addr, a);
  endsequence

  a_read_thr: assert property (@(posedge ref_clk) disable iff (reset)
    s_read_of(`LEI_ADDR_THRESHOLD) |=> bus_rdata == $past(thr_q))
    else $error("threshold read back wrong");
  a_read_le_snap: assert property (@(posedge ref_clk) disable iff (reset)
    s_read_of(`LEI_ADDR_LE_COUNT) |=> bus_rdata == $past(le_cnt_q))
    else $error("link error snapshot wrong");
  a_read_rev: assert property (@(posedge ref_clk) disable iff (reset)
    s_read_of(`LEI_ADDR_REV) |=> bus_rdata == REVISION)
    else $error("revision read back wrong");
  a_read_upper: assert property (@(posedge ref_clk) disable iff (reset)
    s_read_of(`LEI_ADDR_USER) |=> bus_rdata[`LEI_BIT_RES_HI:`LEI_BIT_RES_LO] == 4'h0)
    else $error("reserved user bits read as nonzero");
  a_rdata_hold: assert property (@(posedge ref_clk) disable iff (reset)
    !bus_req.rd |=> $stable(bus_rdata))
    else $error("read data changed without a read");
endmodule : lei_regs

// [testbench/lei_host_model.sv]
`timescale 1ns/1ps
module lei_host_model (
  // clock
  input  wire logic                     ref_clk,
  // control bus
  output lei_regs_pkg::lei_bus_req_type bus_req
);
  initial bus_req = '0;
  // one byte access, held across exactly one rising edge
  task automatic access(input logic r, input logic [4:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    bus_req <= '{rd: r, wr: !r, addr: a, wdata: d};
    @(negedge ref_clk);
    bus_req <= '0;
  endtask : access
endmodule : lei_host_model

// [testbench/lei_regs_tb.sv]
`timescale 1ns/1ps
module lei_regs_tb;
  localparam logic [7:0] REV = 8'h5a;  // value is arbitrary
  logic       ref_clk, reset, byte_tick, link_error, inj_wr, sp0, sp1, hit, rej, ep0, ep1;
  logic [1:0] inj_mode;
  logic [7:0] inj_thr, bus_rdata;
  int         bad_count, checks;
  lei_regs_pkg::lei_bus_req_type bus_req;

  lei_host_model host (.ref_clk(ref_clk), .bus_req(bus_req));
  lei_regs #(.REVISION(REV)) dut (
    .ref_clk(ref_clk), .reset(reset), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .byte_tick(byte_tick), .link_error(link_error), .injection_control(inj_mode),
    .injection_threshold(inj_thr), .injection_threshold_wr(inj_wr),
    .link_error_threshold_hit(hit), .write_reject_flag(rej),
    .sense_pin_0(sp0), .sense_pin_1(sp1), .enable_pin_0(ep0), .enable_pin_1(ep1));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp);
    host.access(1'b1, a, 8'h00);
    chk($sformatf("read %h", a), bus_rdata, exp);
  endtask : rd_chk
  task automatic ticks(input int n);
    repeat (n) begin
      @(negedge ref_clk) byte_tick = 1'b1;
      @(negedge ref_clk) byte_tick = 1'b0;
    end
  endtask : ticks
  task automatic report_and_stop;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset;
    rd_chk(5'h19, 8'h00);
    rd_chk(5'h16, 8'h00);
    rd_chk(5'h17, 8'h00);
    chk("enables", {6'h00, ep1, ep0}, 8'h00);
    rd_chk(5'h18, REV);
    rd_chk(5'h1f, 8'h00);
    $display("test reset done");
  endtask : t_reset
  task automatic t_link;
    logic seen;
    seen = 1'b0;
    host.access(1'b0, 5'h15, 8'h03);
    rd_chk(5'h16, 8'h03);
    @(negedge ref_clk) link_error = 1'b1;
    repeat (2) @(negedge ref_clk);
    link_error = 1'b0;
    rd_chk(5'h16, 8'h01);
    @(negedge ref_clk) link_error = 1'b1;
    @(negedge ref_clk) link_error = 1'b0;
    repeat (4) @(negedge ref_clk) if (hit === 1'b1) seen = 1'b1;
    chk("threshold hit", {7'h00, seen}, 8'h01);
    rd_chk(5'h16, 8'h03);
    $display("test link done");
  endtask : t_link
  task automatic t_reject;
    logic [4:0] addrs [3] = '{5'h16, 5'h18, 5'h19};
    foreach (addrs[i]) begin
      host.access(1'b0, addrs[i], 8'hff);
      chk("reject", {7'h00, rej}, 8'h01);
    end
    rd_chk(5'h16, 8'h03);
    rd_chk(5'h18, REV);
    $display("test reject done");
  endtask : t_reject
  task automatic t_sense;
    sp0 = 1'b1;
    sp1 = 1'b1;
    ticks(3);
    sp0 = 1'b0;
    sp1 = 1'b0;
    ticks(2);
    rd_chk(5'h17, 8'h03);
    host.access(1'b0, 5'h17, 8'h0e);
    chk("no reject", {7'h00, rej}, 8'h00);
    chk("enables", {6'h00, ep1, ep0}, 8'h03);
    rd_chk(5'h17, 8'h0e);
    host.access(1'b0, 5'h17, 8'hf4);
    chk("enables", {6'h00, ep1, ep0}, 8'h01);
    sp0 = 1'b1;
    ticks(1);
    sp0 = 1'b0;
    ticks(2);
    rd_chk(5'h17, 8'h04);
    $display("test sense done");
  endtask : t_sense
  task automatic t_inj;
    inj_thr = 8'h05;
    @(negedge ref_clk) inj_wr = 1'b1;
    @(negedge ref_clk) inj_wr = 1'b0;
    ticks(2);
    rd_chk(5'h19, 8'h05);
    inj_mode = 2'h1;
    ticks(2);
    rd_chk(5'h19, 8'h03);
    inj_mode = 2'h2;
    ticks(2);
    rd_chk(5'h19, 8'h01);
    inj_mode = 2'h3;
    ticks(1);
    rd_chk(5'h19, 8'h01);
    inj_mode = 2'h1;
    ticks(2);
    rd_chk(5'h19, 8'h05);
    $display("test injection done");
  endtask : t_inj
  task automatic t_mid_reset;
    @(negedge ref_clk) reset = 1'b1;
    repeat (3) @(negedge ref_clk);
    reset = 1'b0;
    rd_chk(5'h16, 8'h00);
    rd_chk(5'h19, 8'h00);
    rd_chk(5'h17, 8'h00);
    chk("enables", {6'h00, ep1, ep0}, 8'h00);
    $display("test mid reset done");
  endtask : t_mid_reset

  initial begin
    {reset, byte_tick, link_error, inj_wr, sp0, sp1, inj_mode, inj_thr} = 16'h8000;
    bad_count = 0;
    checks = 0;
    repeat (10) @(negedge ref_clk);
    reset = 1'b0;
    t_reset();
    t_link();
    t_reject();
    t_sense();
    t_inj();
    t_mid_reset();
    report_and_stop();
  end
endmodule : lei_regs_tb
